// >>> ssp_defs.svh
// Behaviour
// RQ1: delay straps decode to 0, 5/10/20 or 50/100/200 ms; low/open reserved
// RQ2: delays of 0 or 5 ms still wait for the 6 ms initialisation
// RQ3: ramp straps decode to 0/1/2, 5/10/20 or 50/100/200 ms
// RQ4: a zero ramp time turns the output fully on with no timed ramp
// RQ5: a resistor on a lower strap picks a time in 10 ms steps
// RQ6: delay and ramp resistors sampled only at start-up or restore
// RQ7: host may overwrite delay and ramp; zero delay still waits init
// RQ8: output good needs no fault and output within host-set window
// RQ9: output good held off for a delay after all conditions are met
// RQ10: output good delay defaults to the ramp time
// RQ11: host may program output good delay independently of ramp time
// RQ12: clock mode strap: low input, open auto-detect, high output
// RQ13: output mode drives the internal 400 kHz clock, ignores the pin
// RQ14: input mode checks for a clock at each enable and locks to it
// RQ15: external clock 200 kHz to 2 MHz, stable before enable
// RQ16: on external clock loss both power switches turn off within 10 us
// RQ17: auto mode locks to a clock, else strap or resistor picks frequency
// RQ18: auto mode reads the shared pin strap only at power-up
// RQ19: a resistor on the shared pin selects frequency from the table
// RQ20: host frequency is 8 MHz divided by N, N from 4 to 40
// RQ21: frequency readback reports the quantised value actually used
// RQ22: only one controller drives the shared clock, or all take one source
// RQ23: delay starts at enable; ramp starts when the delay expires
// RQ24: 10 to 20 ms configuration after reset or restore ignores enable, bus
// RQ25: each three-level strap resolves once into a held two-bit code
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// ==========================================
// timing
`define SSP_CLK_MHZ 32'h64
`define SSP_US_PER_MS 32'h3e8
`define SSP_CFG_MS 9'h00f
`define SSP_INIT_MS 8'h06
`define SSP_DET_US 32'h0a
`define SSP_LOSS_US 32'h08
`define SSP_OSC_STEP 5'h02
`define SSP_OSC_MOD 5'h19
// ==========================================
// strap codes and tables
`define SSP_LVL_LOW 2'h0
`define SSP_LVL_OPEN 2'h1
`define SSP_LVL_HIGH 2'h2
`define SSP_ROW_OPEN_MS 8'h05
`define SSP_ROW_HIGH_MS 8'h32
`define SSP_RES_STEP_MS 8'h0a
`define SSP_RES_MAX_IDX 5'h14
`define SSP_N_LOW 6'h28
`define SSP_N_DEF 6'h14
`define SSP_N_HIGH 6'h08
`define SSP_N_MIN 6'h04
`define SSP_N_MAX 6'h28
`define SSP_BASE_KHZ 16'h1f40
// ==========================================
// register map
`define SSP_REG_CTRL 8'h00
`define SSP_REG_DELAY 8'h04
`define SSP_REG_RAMP 8'h08
`define SSP_REG_PGDLY 8'h0c
`define SSP_REG_FREQN 8'h10
`define SSP_REG_PGWIN 8'h14
`define SSP_REG_STATUS 8'h18
`define SSP_REG_FREQ 8'h1c
`define SSP_PGWIN_LO_RST 8'hf6
`define SSP_PGWIN_HI_RST 8'h0f
`endif

// >>> ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [2:0] {
    SSP_CONFIG,
    SSP_READY,
    SSP_DELAY,
    SSP_RAMP,
    SSP_ON
  } ssp_state_t;
  typedef enum logic [1:0] {
    SSP_CLK_IN,
    SSP_CLK_AUTO,
    SSP_CLK_OUT
  } ssp_clk_mode_t;
endpackage

// >>> ssp_seq_core.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_seq_core #(
  parameter int MS_CYCLES = `SSP_CLK_MHZ * `SSP_US_PER_MS,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable,
  input wire logic [1:0] delay_strap_hi,
  input wire logic [1:0] delay_strap_lo,
  input wire logic [1:0] ramp_strap_hi,
  input wire logic [1:0] ramp_strap_lo,
  input wire logic [1:0] clock_cfg_strap,
  input wire logic [1:0] sync_pin_strap,
  input wire logic delay_res_present,
  input wire logic ramp_res_present,
  input wire logic sync_res_present,
  input wire logic [4:0] delay_res_index,
  input wire logic [4:0] ramp_res_index,
  input wire logic [4:0] sync_res_index,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic fault,
  input wire logic signed [7:0] vout_dev_pct,
  input wire logic hs_drive_req,
  input wire logic ls_drive_req,
  output logic high_side_switch,
  output logic low_side_switch,
  output logic sw_tick,
  output logic ramp_active,
  output logic output_good
);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int DET_CYC = `SSP_DET_US * `SSP_CLK_MHZ;
  localparam int LOSS_CYC = `SSP_LOSS_US * `SSP_CLK_MHZ;

  // ==========================================
  // table functions
  function automatic logic [7:0] strap_ms(input logic [1:0] hi,
    input logic [1:0] lo, input logic rp, input logic [4:0] idx,
    input logic dly);
    logic [7:0] mult;
    mult = (lo == `SSP_LVL_LOW) ? 8'h01 :
           (lo == `SSP_LVL_HIGH) ? 8'h04 : 8'h02;
    if (rp)
      return (idx > `SSP_RES_MAX_IDX) ? 8'(`SSP_RES_MAX_IDX * 10) :
             8'(idx * `SSP_RES_STEP_MS); // RQ5
    else if (hi == `SSP_LVL_LOW)
      return dly ? 8'h00 : (mult >> 1); // RQ1 RQ3
    else if (hi == `SSP_LVL_HIGH)
      return 8'(mult * `SSP_ROW_HIGH_MS);
    else
      return 8'(mult * `SSP_ROW_OPEN_MS);
  endfunction

  function automatic logic [5:0] res_to_n(input logic [4:0] idx);
    unique case (idx)
      5'h00: return 6'h28;
      5'h01: return 6'h24;
      5'h02: return 6'h21;
      5'h03: return 6'h1e;
      5'h04: return 6'h1b;
      5'h05: return 6'h19;
      5'h06: return 6'h16;
      5'h07: return 6'h14;
      5'h08: return 6'h13;
      5'h09: return 6'h11;
      5'h0a: return 6'h0f;
      5'h0b: return 6'h0e;
      5'h0c: return 6'h0d;
      5'h0d: return 6'h0c;
      5'h0e: return 6'h0b;
      5'h10: return 6'h09;
      5'h11: return 6'h08;
      5'h12: return 6'h07;
      5'h14: return 6'h06;
      5'h16: return 6'h05;
      5'h18: return 6'h04;
      default: return `SSP_N_DEF;
    endcase
  endfunction

  // ==========================================
  // pin synchronisers
  logic [31:0] pin_s1;
  logic [31:0] pin_s2;
  logic sync_d;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pin_s1 <= 32'h0;
      pin_s2 <= 32'h0;
      sync_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= {enable, sync_in, delay_strap_hi, delay_strap_lo,
                 ramp_strap_hi, ramp_strap_lo, clock_cfg_strap,
                 sync_pin_strap, delay_res_present, ramp_res_present,
                 sync_res_present, delay_res_index, ramp_res_index,
                 sync_res_index};
      pin_s2 <= pin_s1;
      sync_d <= pin_s2[30];
    end
  wire en_s = pin_s2[31];
  wire ext_edge = pin_s2[30] & ~sync_d;

  // ==========================================
  // millisecond tick
  logic [MSW-1:0] ms_cnt;
  logic ms_tick;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else if (ms_cnt == MSW'(MS_CYCLES - 1))
    begin
      ms_cnt <= '0;
      ms_tick <= 1'b1;
    end
    else
    begin
      ms_cnt <= ms_cnt + 1'b1;
      ms_tick <= 1'b0;
    end

  // ==========================================
  // host registers and latched straps
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_clk_mode_t clk_mode;
  logic [8:0] seq_ms;
  logic [7:0] dly_pin, ramp_pin, dly_host, ramp_host, pgd_host;
  logic dly_ovr, ramp_ovr, pgd_ovr, freq_ovr, sync_taken;
  logic [5:0] auto_n, host_n;
  logic signed [7:0] win_lo, win_hi;
  logic locked, lost, detecting;
  wire busy = (state == ssp_pkg::SSP_CONFIG);
  logic mapped;
  wire wr_ok = psel & penable & pwrite & mapped & ~busy; // RQ24
  wire [7:0] addr8 = 8'(paddr);
  wire restore_req = wr_ok & (addr8 == `SSP_REG_CTRL) & pwdata[0];
  wire cfg_done = busy & ms_tick & (seq_ms == `SSP_CFG_MS - 9'h001);
  wire [7:0] dly_eff = dly_ovr ? dly_host : dly_pin; // RQ7
  wire [7:0] ramp_eff = ramp_ovr ? ramp_host : ramp_pin;
  wire [7:0] pgd_eff = pgd_ovr ? pgd_host : ramp_eff; // RQ10 RQ11
  wire [5:0] n_eff = freq_ovr ? host_n : auto_n;
  // short delays stretch to cover the internal initialisation
  wire [7:0] wait_ms = (dly_eff < `SSP_INIT_MS) ? `SSP_INIT_MS
                                                : dly_eff; // RQ2

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      dly_pin <= 8'h00;
      ramp_pin <= 8'h00;
      clk_mode <= ssp_pkg::SSP_CLK_AUTO;
      auto_n <= `SSP_N_DEF;
      sync_taken <= 1'b0;
    end
    else if (cfg_done)
    begin
      // resistors and straps are caught here only, never tracked
      dly_pin <= strap_ms(pin_s2[29:28], pin_s2[27:26], pin_s2[17],
                          pin_s2[14:10], 1'b1); // RQ1 RQ6 RQ25
      ramp_pin <= strap_ms(pin_s2[25:24], pin_s2[23:22], pin_s2[16],
                           pin_s2[9:5], 1'b0); // RQ3 RQ6 RQ25
      if (!sync_taken)
      begin
        sync_taken <= 1'b1; // RQ18
        unique case (pin_s2[21:20])
          `SSP_LVL_LOW: clk_mode <= ssp_pkg::SSP_CLK_IN; // RQ12
          `SSP_LVL_HIGH: clk_mode <= ssp_pkg::SSP_CLK_OUT;
          default: clk_mode <= ssp_pkg::SSP_CLK_AUTO;
        endcase
        if (pin_s2[21:20] != `SSP_LVL_OPEN || pin_s2[15])
          auto_n <= `SSP_N_DEF; // RQ13
        else if (pin_s2[19:18] == `SSP_LVL_LOW)
          auto_n <= `SSP_N_LOW; // RQ17
        else if (pin_s2[19:18] == `SSP_LVL_HIGH)
          auto_n <= `SSP_N_HIGH;
        else
          auto_n <= `SSP_N_DEF;
        if (pin_s2[21:20] == `SSP_LVL_OPEN && pin_s2[15])
          auto_n <= res_to_n(pin_s2[4:0]); // RQ19
      end
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {dly_ovr, ramp_ovr, pgd_ovr, freq_ovr} <= 4'h0;
      dly_host <= 8'h00;
      ramp_host <= 8'h00;
      pgd_host <= 8'h00;
      host_n <= `SSP_N_DEF;
      win_lo <= `SSP_PGWIN_LO_RST;
      win_hi <= `SSP_PGWIN_HI_RST;
    end
    else if (restore_req)
      {dly_ovr, ramp_ovr, pgd_ovr, freq_ovr} <= 4'h0;
    else if (wr_ok)
      unique case (addr8)
        `SSP_REG_DELAY:
        begin
          dly_host <= pwdata[7:0]; // RQ7
          dly_ovr <= 1'b1;
        end
        `SSP_REG_RAMP:
        begin
          ramp_host <= pwdata[7:0];
          ramp_ovr <= 1'b1;
        end
        `SSP_REG_PGDLY:
        begin
          pgd_host <= pwdata[7:0]; // RQ11
          pgd_ovr <= 1'b1;
        end
        `SSP_REG_FREQN:
          // out-of-range divisors are dropped, keeping 200 kHz..2 MHz
          if (pwdata[5:0] >= `SSP_N_MIN && pwdata[5:0] <= `SSP_N_MAX
              && pwdata[31:6] == 26'h0)
          begin
            host_n <= pwdata[5:0]; // RQ20
            freq_ovr <= 1'b1;
          end
        `SSP_REG_PGWIN:
        begin
          win_lo <= pwdata[7:0]; // RQ8
          win_hi <= pwdata[15:8];
        end
        default: ;
      endcase

  // ==========================================
  // start-up sequence
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= ssp_pkg::SSP_CONFIG;
      seq_ms <= 9'h000;
    end
    else if (restore_req)
    begin
      state <= ssp_pkg::SSP_CONFIG; // RQ24
      seq_ms <= 9'h000;
    end
    else
      unique case (state)
        ssp_pkg::SSP_CONFIG:
          if (cfg_done)
          begin
            state <= ssp_pkg::SSP_READY;
            seq_ms <= 9'h000;
          end
          else if (ms_tick)
            seq_ms <= seq_ms + 9'h001;
        ssp_pkg::SSP_READY:
          if (en_s)
          begin
            state <= ssp_pkg::SSP_DELAY; // RQ23
            seq_ms <= 9'h000;
          end
        ssp_pkg::SSP_DELAY:
          if (!en_s)
            state <= ssp_pkg::SSP_READY;
          else if (ms_tick)
          begin
            if (seq_ms + 9'h001 >= {1'b0, wait_ms})
            begin
              state <= ssp_pkg::SSP_RAMP; // RQ23
              seq_ms <= 9'h000;
            end
            else
              seq_ms <= seq_ms + 9'h001;
          end
        ssp_pkg::SSP_RAMP:
          if (!en_s)
            state <= ssp_pkg::SSP_READY;
          else if (ramp_eff == 8'h00)
            state <= ssp_pkg::SSP_ON; // RQ4
          else if (ms_tick)
          begin
            if (seq_ms + 9'h001 >= {1'b0, ramp_eff})
              state <= ssp_pkg::SSP_ON;
            else
              seq_ms <= seq_ms + 9'h001;
          end
        ssp_pkg::SSP_ON:
          if (!en_s)
            state <= ssp_pkg::SSP_READY;
        default:
          state <= ssp_pkg::SSP_CONFIG;
      endcase

  // ==========================================
  // external clock detection and loss
  wire start_det = (state == ssp_pkg::SSP_READY) & en_s;
  logic [$clog2(DET_CYC)-1:0] det_cnt;
  logic [$clog2(LOSS_CYC)-1:0] gap_cnt;
  logic [1:0] edges;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      detecting <= 1'b0;
      locked <= 1'b0;
      lost <= 1'b0;
      det_cnt <= '0;
      gap_cnt <= '0;
      edges <= 2'h0;
    end
    else if (start_det)
    begin
      // output mode never samples the pin
      detecting <= (clk_mode != ssp_pkg::SSP_CLK_OUT); // RQ13 RQ14
      locked <= 1'b0;
      lost <= 1'b0;
      det_cnt <= '0;
      edges <= 2'h0;
    end
    else if (!en_s)
    begin
      detecting <= 1'b0;
      locked <= 1'b0;
      lost <= 1'b0;
    end
    else if (detecting)
    begin
      det_cnt <= det_cnt + 1'b1;
      gap_cnt <= '0;
      if (ext_edge && edges != 2'h2)
        edges <= edges + 2'h1;
      if (det_cnt == ($clog2(DET_CYC))'(DET_CYC - 1))
      begin
        detecting <= 1'b0;
        locked <= (edges == 2'h2); // RQ14 RQ17
        // input mode without a clock holds the switches off from the end of the search on
        lost <= (edges != 2'h2) && (clk_mode == ssp_pkg::SSP_CLK_IN);
      end
    end
    else if (locked)
    begin
      if (ext_edge)
        gap_cnt <= '0;
      else if (gap_cnt == ($clog2(LOSS_CYC))'(LOSS_CYC - 1))
      begin
        locked <= 1'b0;
        lost <= 1'b1; // RQ16
      end
      else
        gap_cnt <= gap_cnt + 1'b1;
    end

  // ==========================================
  // internal oscillator: 8 MHz by fractional step, then divide by N
  logic [4:0] osc_acc;
  logic [5:0] div_cnt;
  logic tick8;
  wire [4:0] acc_sum = osc_acc + `SSP_OSC_STEP;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      osc_acc <= 5'h00;
      tick8 <= 1'b0;
      div_cnt <= 6'h00;
    end
    else
    begin
      tick8 <= (acc_sum >= `SSP_OSC_MOD);
      osc_acc <= (acc_sum >= `SSP_OSC_MOD) ? acc_sum - `SSP_OSC_MOD
                                           : acc_sum;
      if (tick8)
        div_cnt <= (div_cnt >= n_eff - 6'h01) ? 6'h00
                                              : div_cnt + 6'h01; // RQ20
    end
  wire osc_tick = tick8 & (div_cnt == 6'h00);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
      sw_tick <= 1'b0;
    end
    else
    begin
      sync_oe <= (clk_mode == ssp_pkg::SSP_CLK_OUT) & ~busy; // RQ13
      sync_out <= (div_cnt < {1'b0, n_eff[5:1]});
      if (locked)
        sw_tick <= ext_edge; // RQ14
      else
        sw_tick <= osc_tick & (clk_mode != ssp_pkg::SSP_CLK_IN);
    end

  // ==========================================
  // power switch gating
  wire run = (state == ssp_pkg::SSP_RAMP || state == ssp_pkg::SSP_ON)
             & ~lost;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      high_side_switch <= 1'b0;
      low_side_switch <= 1'b0;
      ramp_active <= 1'b0;
    end
    else
    begin
      high_side_switch <= hs_drive_req & run; // RQ16
      low_side_switch <= ls_drive_req & run; // RQ16
      ramp_active <= (state == ssp_pkg::SSP_RAMP) & ~lost;
    end

  // ==========================================
  // output good
  wire pg_cond = (state == ssp_pkg::SSP_ON) & ~fault & ~lost &
                 (vout_dev_pct >= win_lo) & (vout_dev_pct <= win_hi);
  logic [7:0] pg_ms;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      output_good <= 1'b0;
      pg_ms <= 8'h00;
    end
    else if (!pg_cond)
    begin
      output_good <= 1'b0; // RQ8
      pg_ms <= 8'h00;
    end
    else if (!output_good)
    begin
      if (pgd_eff == 8'h00 ||
          (ms_tick && pg_ms + 8'h01 >= pgd_eff))
        output_good <= 1'b1; // RQ9
      else if (ms_tick)
        pg_ms <= pg_ms + 8'h01;
    end

  // ==========================================
  // register bus
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0;
    mapped = 1'b1;
    unique case (addr8)
      `SSP_REG_CTRL: rd_val = 32'h0;
      `SSP_REG_DELAY: rd_val = {24'h0, dly_eff};
      `SSP_REG_RAMP: rd_val = {24'h0, ramp_eff};
      `SSP_REG_PGDLY: rd_val = {24'h0, pgd_eff};
      `SSP_REG_FREQN: rd_val = {26'h0, n_eff};
      `SSP_REG_PGWIN: rd_val = {16'h0, win_hi, win_lo};
      `SSP_REG_STATUS:
        rd_val = {22'h0, detecting, clk_mode, lost, locked, output_good,
                  state == ssp_pkg::SSP_ON, state == ssp_pkg::SSP_RAMP,
                  state == ssp_pkg::SSP_DELAY, ~busy};
      `SSP_REG_FREQ:
        rd_val = {16'h0, 16'(`SSP_BASE_KHZ / {10'h0, n_eff})}; // RQ21
      default: mapped = 1'b0;
    endcase
    if (paddr != ADDR_W'(addr8))
      mapped = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_val;

  assign pready = 1'b1;
  assign pslverr = psel & penable & (~mapped | busy); // RQ24
endmodule

// >>> ssp_seq_core_sva.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the sequencer
module ssp_seq_core_sva #(
  parameter int MS_CYCLES = 100000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic enable,
  input wire logic fault,
  input wire logic hs_drive_req,
  input wire logic ls_drive_req,
  input wire logic high_side_switch,
  input wire logic low_side_switch,
  input wire logic ramp_active,
  input wire logic output_good,
  input wire logic sync_oe
);
  localparam int CFG_QUIET = 14 * MS_CYCLES;
  localparam int MIN_WAIT = 5 * MS_CYCLES;
  int cfg_cnt;
  int en_cnt;
  // ==========================================
  // helper counters, saturating so a long run never wraps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_cnt <= 0;
    else if (cfg_cnt < CFG_QUIET)
      cfg_cnt <= cfg_cnt + 1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      en_cnt <= 0;
    else if (!enable)
      en_cnt <= 0;
    else if (en_cnt < MIN_WAIT)
      en_cnt <= en_cnt + 1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // assertions
  a_hs_needs_req:
    assert property (high_side_switch |-> $past(hs_drive_req))
    else $error("high side switch on without a request");
  a_ls_needs_req:
    assert property ($rose(low_side_switch) |-> $past(ls_drive_req))
    else $error("low side switch on without a request");
  a_fault_drops_good:
    assert property ($rose(fault) |=> !output_good)
    else $error("output good stayed up during a fault");
  a_no_good_ramping:
    assert property (ramp_active |-> !output_good)
    else $error("output good raised while still ramping");
  a_enable_low_stops:
    assert property (!enable [*5] |-> !ramp_active)
    else $error("ramp running with enable low");
  a_init_wait_kept:
    assert property ($rose(ramp_active) |-> en_cnt >= MIN_WAIT)
    else $error("ramp started before initialisation wait");
  a_config_quiet:
    assert property (cfg_cnt < CFG_QUIET |->
      !sync_oe && !ramp_active && !output_good)
    else $error("outputs active during configuration");
  a_config_bus_err:
    assert property (cfg_cnt < CFG_QUIET && psel && penable |-> pslverr)
    else $error("bus accepted during configuration");
  cover property ($rose(output_good));
  cover property ($rose(ramp_active));
  cover property (psel && penable && pslverr);
  cover property ($fell(high_side_switch));
endmodule

bind ssp_seq_core ssp_seq_core_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pslverr(pslverr), .enable(enable), .fault(fault),
  .hs_drive_req(hs_drive_req), .ls_drive_req(ls_drive_req),
  .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
  .ramp_active(ramp_active), .output_good(output_good), .sync_oe(sync_oe)
);

// >>> ssp_ext_clk.sv
`timescale 1ns/1ps
// ==========================================
// external clock source on the shared pin
module ssp_ext_clk #(
  parameter real HALF_NS = 503.7
) (
  input wire logic run,
  output logic clk_out
);
  // near 1 MHz, inside 200 kHz to 2 MHz; odd half period keeps phase apart
  always
  begin
    #(HALF_NS);
    // a stopped source parks low, so loss shows as missing edges
    clk_out = run && clk_out === 1'b0;
  end
endmodule

// >>> soft_start_pgood_sync_config_bench.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module soft_start_pgood_sync_config_bench;
  localparam int MS = 32'h64;
  localparam int LIMIT = 32'hea60;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, enable, fault, src_run, src_clk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, sync_in, sync_out, sync_oe, hs_drive_req;
  logic [1:0] delay_strap_hi, delay_strap_lo, ramp_strap_hi, ramp_strap_lo;
  logic [1:0] clock_cfg_strap, sync_pin_strap;
  logic delay_res_present, ramp_res_present, sync_res_present, ls_drive_req;
  logic [4:0] delay_res_index, ramp_res_index, sync_res_index;
  logic signed [7:0] vout_dev_pct;
  logic high_side_switch, low_side_switch, sw_tick, ramp_active, output_good;
  logic [7:0] dly_t [9] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h0a, 8'h14,
    8'h32, 8'h64, 8'hc8};
  logic [7:0] rmp_t [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0a, 8'h14,
    8'h32, 8'h64, 8'hc8};
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #5 clk = ~clk;
  // the pin is ours while sync_oe is high, else the source owns it
  assign sync_in = sync_oe ? sync_out : src_clk;
  ssp_ext_clk src_u (.run(src_run), .clk_out(src_clk));
  ssp_seq_core #(.MS_CYCLES(MS)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable(enable),
    .delay_strap_hi(delay_strap_hi), .delay_strap_lo(delay_strap_lo),
    .ramp_strap_hi(ramp_strap_hi), .ramp_strap_lo(ramp_strap_lo),
    .clock_cfg_strap(clock_cfg_strap), .sync_pin_strap(sync_pin_strap),
    .delay_res_present(delay_res_present),
    .ramp_res_present(ramp_res_present), .sync_res_present(sync_res_present),
    .delay_res_index(delay_res_index), .ramp_res_index(ramp_res_index),
    .sync_res_index(sync_res_index), .sync_in(sync_in),
    .sync_out(sync_out), .sync_oe(sync_oe), .fault(fault),
    .vout_dev_pct(vout_dev_pct), .hs_drive_req(hs_drive_req),
    .ls_drive_req(ls_drive_req), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .sw_tick(sw_tick),
    .ramp_active(ramp_active), .output_good(output_good));
  // ==========================================
  // bus and sequencing tasks
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic x);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic y;
    apb(1'b0, a, 32'h0, r, y);
    `CHK(r, x)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic y;
    apb(1'b1, a, d, r, y);
  endtask
  task automatic wait_ready;
    logic [31:0] r;
    logic y;
    r = 32'h0;
    while (r[0] !== 1'b1) apb(1'b0, `SSP_REG_STATUS, 32'h0, r, y);
  endtask
  task automatic restore;
    wr(`SSP_REG_CTRL, 32'h1);
    wait_ready;
  endtask
  // fixed wait covers the 6 ms start and the 10 us clock search, which run side by side
  task automatic boot(input logic [1:0] cfg);
    @(posedge clk);
    enable <= 1'b0;
    clock_cfg_strap <= cfg;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready;
    enable <= 1'b1;
    repeat (1200) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      errors++;
      summarize;
    end
  end
  // ==========================================
  // tests
  initial
  begin
    {rst_n, psel, penable, pwrite, enable, fault, src_run} = 7'h0;
    {paddr, pwdata, vout_dev_pct} = 48'h0;
    {delay_strap_hi, delay_strap_lo, ramp_strap_hi, ramp_strap_lo} = 8'h0;
    {clock_cfg_strap, sync_pin_strap} = 4'h1;
    {delay_res_present, ramp_res_present, sync_res_present} = 3'h0;
    {delay_res_index, ramp_res_index, sync_res_index} = 15'h0;
    {hs_drive_req, ls_drive_req} = 2'h3;
    boot(2'h2);
    `CHK(sync_oe, 1'b1)
    apb(1'b0, `SSP_REG_STATUS, 32'h0, q, e);
    `CHK(q[8:7], 2'h2)
    rchk(`SSP_REG_FREQ, 32'h190);
    wr(`SSP_REG_FREQN, 32'h7);
    rchk(`SSP_REG_FREQ, 32'h476);
    wr(`SSP_REG_FREQN, 32'h3);
    wr(`SSP_REG_FREQN, 32'h29);
    rchk(`SSP_REG_FREQ, 32'h476);
    wr(`SSP_REG_FREQN, 32'h4);
    rchk(`SSP_REG_FREQ, 32'h7d0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK(e, 1'b1)
    $display("test clock output done");
    enable <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      delay_strap_hi <= 2'(i / 3);
      delay_strap_lo <= 2'(i % 3);
      ramp_strap_hi <= 2'(i / 3);
      ramp_strap_lo <= 2'(i % 3);
      restore;
      rchk(`SSP_REG_DELAY, 32'(dly_t[i]));
      rchk(`SSP_REG_RAMP, 32'(rmp_t[i]));
      rchk(`SSP_REG_PGDLY, 32'(rmp_t[i]));
    end
    $display("test strap tables done");
    delay_res_present <= 1'b1;
    delay_res_index <= 5'h07;
    ramp_res_present <= 1'b1;
    ramp_res_index <= 5'h02;
    restore;
    rchk(`SSP_REG_DELAY, 32'h46);
    rchk(`SSP_REG_RAMP, 32'h14);
    delay_res_index <= 5'h14;
    rchk(`SSP_REG_DELAY, 32'h46);
    $display("test resistors done");
    wr(`SSP_REG_DELAY, 32'h0);
    wr(`SSP_REG_RAMP, 32'h3);
    wr(`SSP_REG_PGDLY, 32'h2);
    rchk(`SSP_REG_DELAY, 32'h0);
    rchk(`SSP_REG_RAMP, 32'h3);
    rchk(`SSP_REG_PGDLY, 32'h2);
    @(posedge clk);
    enable <= 1'b1;
    for (n = 0; ramp_active !== 1'b1; n++) @(posedge clk);
    `CHK(n >= 5 * MS && n <= 6 * MS + 10, 1'b1)
    for (n = 0; ramp_active === 1'b1; n++) @(posedge clk);
    `CHK(n >= 2 * MS && n <= 3 * MS + 10, 1'b1)
    for (n = 0; output_good !== 1'b1; n++) @(posedge clk);
    `CHK(n >= MS && n <= 2 * MS + 10, 1'b1)
    vout_dev_pct <= 8'sh10;
    repeat (3) @(posedge clk);
    `CHK(output_good, 1'b0)
    wr(`SSP_REG_PGWIN, 32'h20f6);
    repeat (250) @(posedge clk);
    `CHK(output_good, 1'b1)
    vout_dev_pct <= 8'sh00;
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(output_good, 1'b0)
    fault <= 1'b0;
    $display("test sequence done");
    {delay_res_present, ramp_res_present} <= 2'h0;
    {delay_strap_hi, delay_strap_lo, ramp_strap_hi, ramp_strap_lo} <= 8'h0;
    src_run <= 1'b1;
    boot(2'h0);
    apb(1'b0, `SSP_REG_STATUS, 32'h0, q, e);
    `CHK(q[8:7], 2'h0)
    `CHK(q[5], 1'b1)
    `CHK(sync_oe, 1'b0)
    `CHK(high_side_switch, 1'b1)
    for (n = 0; sw_tick !== 1'b1 && n < 200; n++) @(posedge clk);
    `CHK(sw_tick, 1'b1)
    src_run <= 1'b0;
    repeat (1000) @(posedge clk);
    `CHK(high_side_switch, 1'b0)
    `CHK(low_side_switch, 1'b0)
    apb(1'b0, `SSP_REG_STATUS, 32'h0, q, e);
    `CHK(q[6], 1'b1)
    $display("test clock input done");
    sync_pin_strap <= 2'h2;
    boot(2'h1);
    apb(1'b0, `SSP_REG_STATUS, 32'h0, q, e);
    `CHK(q[8:7], 2'h1)
    rchk(`SSP_REG_FREQ, 32'h3e8);
    sync_pin_strap <= 2'h0;
    restore;
    rchk(`SSP_REG_FREQ, 32'h3e8);
    sync_res_present <= 1'b1;
    boot(2'h1);
    rchk(`SSP_REG_FREQ, 32'hc8);
    $display("test clock auto done");
    summarize;
  end
endmodule
